// file: cos_pkg.sv
package cos_pkg;
    // Timebase
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_LOCK_NS = 1800000;
    localparam int LOCK_CYCLES = T_LOCK_NS / CLK_PERIOD_NS;
    localparam int DIFF_DIV = 2;
    localparam int N_PARK_PERIODS = 4;
    localparam int PARK_CYCLES = N_PARK_PERIODS * DIFF_DIV;

    // Output and request counts
    localparam int N_REQ = 2;
    localparam int N_SRC = 8;
    localparam int N_CPU = 2;
    localparam int N_BUS = 4;
    localparam int N_FREE = 2;
    localparam int N_SYNC = N_REQ + 3;

    // Register map, byte addresses
    localparam int ADR_W = 8;
    localparam logic [7:0] REG_REQ_MAP0 = 8'h00;
    localparam logic [7:0] REG_REQ_MAP1 = 8'h04;
    localparam logic [7:0] REG_SRC_BUS_STOP = 8'h08;
    localparam logic [7:0] REG_SRC_MODE = 8'h0C;
    localparam logic [7:0] REG_CPU_CFG = 8'h10;
    localparam logic [7:0] REG_MISC = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;

    // Reset values
    localparam logic [7:0] RST_REQ_MAP = 8'h00;
    localparam logic [7:0] RST_SRC_BUS_STOP = 8'h00;
    localparam logic [7:0] RST_SRC_MODE = 8'h00;
    localparam logic [7:0] RST_CPU_CFG = 8'h03;
    localparam logic [7:0] RST_MISC = 8'h01;

    // Field positions
    localparam int CPU_STOP_LSB = 0;
    localparam int CPU_MODE_LSB = 4;
    localparam int MISC_DISP100_BIT = 0;
    localparam int MISC_DOT_MODE_BIT = 1;
    localparam int MISC_DISP_MODE_BIT = 2;
    localparam int MISC_FREE_LSB = 4;
    localparam int ST_PD_BIT = 0;
    localparam int ST_LOCK_BIT = 1;
    localparam int ST_CPU_HALT_BIT = 2;
    localparam int ST_BUS_HALT_BIT = 3;
    localparam int ST_SRC_RUN_LSB = 8;

    // Synchroniser idle levels: requests off, halts off, shared pin not yet good
    localparam logic [N_SYNC-1:0] SYNC_IDLE = 5'h1F;

    typedef enum logic [2:0] {
        ST_WAIT_PG = 3'b000,
        ST_LOCK = 3'b001,
        ST_RUN = 3'b010,
        ST_PARK = 3'b011,
        ST_OFF = 3'b100
    } cos_state_t;

    // Pair drive {true, comp, true_oe, comp_oe}
    function automatic logic [3:0] cos_pair(input logic ph, input logic run,
                                            input logic park, input logic park_tri,
                                            input logic release_hi, input logic stop_hi,
                                            input logic stop_tri);
        logic [3:0] v;
        v = 4'h0;
        if (park) begin
            if (!park_tri) begin
                v = 4'hA;
            end else if (release_hi) begin
                v = 4'hB;
            end else begin
                v = 4'h0;
            end
        end else if (run) begin
            v = {ph, ~ph, 2'b11};
        end else if (stop_tri) begin
            v = 4'h0;
        end else if (stop_hi) begin
            v = 4'hB;
        end else begin
            v = 4'h3;
        end
        return v;
    endfunction : cos_pair
endpackage : cos_pkg

// file: cos_sync.sv
`timescale 1ns/1ns
module cos_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= IDLE;
            s2_q <= IDLE;
            s3_q <= IDLE;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A level counts only once it held over two sampling edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= IDLE;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : cos_sync

// file: cos_pwr_seq.sv
`timescale 1ns/1ns
module cos_pwr_seq
    import cos_pkg::*;
#(
    parameter int LOCK_CYC = cos_pkg::LOCK_CYCLES,
    parameter int PARK_CYC = cos_pkg::PARK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_level,
    output cos_pkg::cos_state_t state,
    output logic park,
    output logic osc_en,
    output logic release_hi,
    output logic locked
);
    cos_state_t state_q;
    cos_state_t state_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 32'h1;
        case (state_q)
            ST_WAIT_PG: begin
                cnt_d = 32'h0;
                if (!pin_level) begin
                    state_d = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (pin_level) begin
                    state_d = ST_PARK;
                    cnt_d = 32'h0;
                end else if (cnt_q >= 32'(LOCK_CYC - 1)) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                cnt_d = 32'h0;
                if (pin_level) begin
                    state_d = ST_PARK;
                end
            end
            ST_PARK: begin
                // Oscillators keep running until every output is parked
                if (cnt_q >= 32'(PARK_CYC - 1)) begin
                    state_d = ST_OFF;
                end
            end
            ST_OFF: begin
                cnt_d = 32'h0;
                if (!pin_level) begin
                    state_d = ST_LOCK;
                end
            end
            default: begin
                state_d = ST_WAIT_PG;
                cnt_d = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_WAIT_PG;
            cnt_q <= 32'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign state = state_q;
    assign park = (state_q != ST_RUN);
    assign osc_en = (state_q == ST_LOCK) || (state_q == ST_RUN) || (state_q == ST_PARK);
    assign release_hi = (state_q == ST_LOCK);
    assign locked = (state_q == ST_RUN);
endmodule : cos_pwr_seq

// file: cos_top.sv
`timescale 1ns/1ns
// Functional notes
// - Request inputs are active low; low runs mapped outputs, high lets them stop.
// - One configuration byte per request input selects its controlled outputs.
// - A request change counts only after holding over two sampling edges.
// - On request low, stopped outputs restart together, glitch-free, within 2-6 periods.
// - On request low, stopped outputs are driven high within 10 ns of synchronising.
// - On request high, stoppable outputs stop after next transition, ending low/low.
// - Shared pin is power-good first, then power-down once seen low.
// - Power-down is asynchronous, active high, synchronised before shutdown.
// - Bus clocks parked low and differential pairs parked by drive mode before oscillators and crystal stop.
// - Single-ended park at next fall, differential at next complement fall, within 4.
// - Drive mode 0 parks true line high, complement tri-stated.
// - Drive mode 1 parks both lines tri-stated.
// - Display clock follows dot stop at 96 MHz, serial-reference at 100 MHz.
// - Stable clocks within 1.8 ms of power-down release or supply ramp.
// - Tri-stated differential outputs driven high within 300 us of release.
// - After lock, all outputs enable within a few cycles of each other.
// - Processor halt stops stoppable processor outputs 2-6 periods after synchronising.
// - Stopped processor pairs high/low when driven, low/low when tri-stated.
// - Bus halt stops bus and stoppable serial-reference outputs; free-running ones continue.
// - Stopped bus outputs low; serial-reference pairs high/low or low/low by mode.
// - On bus halt release, bus outputs restart synchronously within two bus periods.
// - Per-output bit: serial-reference output stops with bus halt (1) or runs (0).
module cos_top
    import cos_pkg::*;
#(
    parameter int LOCK_CYC = cos_pkg::LOCK_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [cos_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [cos_pkg::N_REQ-1:0] SERIAL_REF_REQUEST_N,
    input wire logic TERMINATION_POWER_GOOD_N,
    input wire logic PROCESSOR_CLOCK_HALT_N,
    input wire logic BUS_CLOCK_HALT_N,
    output logic [cos_pkg::N_SRC-1:0] SRC_T,
    output logic [cos_pkg::N_SRC-1:0] SRC_C,
    output logic [cos_pkg::N_SRC-1:0] SRC_T_OE,
    output logic [cos_pkg::N_SRC-1:0] SRC_C_OE,
    output logic [cos_pkg::N_CPU-1:0] CPU_T,
    output logic [cos_pkg::N_CPU-1:0] CPU_C,
    output logic [cos_pkg::N_CPU-1:0] CPU_T_OE,
    output logic [cos_pkg::N_CPU-1:0] CPU_C_OE,
    output logic DOT_T,
    output logic DOT_C,
    output logic DOT_T_OE,
    output logic DOT_C_OE,
    output logic DISP_T,
    output logic DISP_C,
    output logic DISP_T_OE,
    output logic DISP_C_OE,
    output logic [cos_pkg::N_BUS-1:0] BUS_CLK,
    output logic [cos_pkg::N_FREE-1:0] FREE_BUS_CLK,
    output logic OSC_ENABLE,
    output logic PLL_ENABLE
);
    import cos_pkg::*;

    logic [N_SYNC-1:0] sync_q;
    logic [N_REQ-1:0] req_low;
    logic power_down_input;
    logic cpu_halt;
    logic bus_halt;
    cos_state_t pstate;
    logic park;
    logic osc_en;
    logic release_hi;
    logic locked;

    logic [7:0] req_map_q [N_REQ];
    logic [7:0] src_bus_stop_q;
    logic [7:0] src_mode_q;
    logic [7:0] cpu_cfg_q;
    logic [7:0] misc_q;
    logic bus_req;
    logic [31:0] rd_d;

    logic ph_q;
    logic ph_d;
    logic [1:0] bcnt_q;
    logic [1:0] bcnt_d;
    logic park_diff_q;
    logic park_diff_d;
    logic park_bus_q;
    logic park_bus_d;
    logic [N_SRC-1:0] run_src_q;
    logic [N_SRC-1:0] run_src_d;
    logic [N_CPU-1:0] run_cpu_q;
    logic [N_CPU-1:0] run_cpu_d;
    logic run_bus_q;
    logic run_bus_d;
    logic [N_FREE-1:0] run_free_q;
    logic [N_FREE-1:0] run_free_d;
    logic [N_SRC-1:0] stop_src;
    logic [N_SRC-1:0] by_bus;
    logic [N_SRC-1:0] wanted;
    logic [N_SRC-1:0] mapped;
    logic [N_CPU-1:0] stop_cpu;
    logic [N_FREE-1:0] stop_free;
    logic diff_rise;
    logic diff_fall;
    logic bus_rise;
    logic bus_fall;

    cos_sync #(
        .W(N_SYNC),
        .IDLE(SYNC_IDLE)
    ) u_sync (
        .clk(CLK),
        .rst(RST),
        .d({BUS_CLOCK_HALT_N, PROCESSOR_CLOCK_HALT_N, TERMINATION_POWER_GOOD_N,
            SERIAL_REF_REQUEST_N}),
        .q(sync_q)
    );

    assign req_low = ~sync_q[N_REQ-1:0];
    assign power_down_input = sync_q[N_REQ];
    assign cpu_halt = ~sync_q[N_REQ+1];
    assign bus_halt = ~sync_q[N_REQ+2];

    cos_pwr_seq #(
        .LOCK_CYC(LOCK_CYC),
        .PARK_CYC(PARK_CYCLES)
    ) u_seq (
        .clk(CLK),
        .rst(RST),
        .pin_level(power_down_input),
        .state(pstate),
        .park(park),
        .osc_en(osc_en),
        .release_hi(release_hi),
        .locked(locked)
    );

    // Wishbone slave: one wait state, unmapped reads return zero
    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int k = 0; k < N_REQ; k++) begin
                req_map_q[k] <= RST_REQ_MAP;
            end
            src_bus_stop_q <= RST_SRC_BUS_STOP;
            src_mode_q <= RST_SRC_MODE;
            cpu_cfg_q <= RST_CPU_CFG;
            misc_q <= RST_MISC;
        end else if (bus_req && WB_WE_I && WB_SEL_I[0]) begin
            if (WB_ADR_I == REG_REQ_MAP0) begin
                req_map_q[0] <= WB_DAT_I[7:0];
            end else if (WB_ADR_I == REG_REQ_MAP1) begin
                req_map_q[1] <= WB_DAT_I[7:0];
            end else if (WB_ADR_I == REG_SRC_BUS_STOP) begin
                src_bus_stop_q <= WB_DAT_I[7:0];
            end else if (WB_ADR_I == REG_SRC_MODE) begin
                src_mode_q <= WB_DAT_I[7:0];
            end else if (WB_ADR_I == REG_CPU_CFG) begin
                cpu_cfg_q <= WB_DAT_I[7:0];
            end else if (WB_ADR_I == REG_MISC) begin
                misc_q <= WB_DAT_I[7:0];
            end
        end
    end

    always_comb begin
        rd_d = 32'h0;
        if (WB_ADR_I == REG_REQ_MAP0) begin
            rd_d[7:0] = req_map_q[0];
        end else if (WB_ADR_I == REG_REQ_MAP1) begin
            rd_d[7:0] = req_map_q[1];
        end else if (WB_ADR_I == REG_SRC_BUS_STOP) begin
            rd_d[7:0] = src_bus_stop_q;
        end else if (WB_ADR_I == REG_SRC_MODE) begin
            rd_d[7:0] = src_mode_q;
        end else if (WB_ADR_I == REG_CPU_CFG) begin
            rd_d[7:0] = cpu_cfg_q;
        end else if (WB_ADR_I == REG_MISC) begin
            rd_d[7:0] = misc_q;
        end else if (WB_ADR_I == REG_STATUS) begin
            rd_d[ST_PD_BIT] = (pstate == ST_PARK) || (pstate == ST_OFF);
            rd_d[ST_LOCK_BIT] = locked;
            rd_d[ST_CPU_HALT_BIT] = cpu_halt;
            rd_d[ST_BUS_HALT_BIT] = bus_halt;
            rd_d[ST_SRC_RUN_LSB +: N_SRC] = run_src_q;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WB_DAT_O <= 32'h0;
        end else if (bus_req) begin
            WB_DAT_O <= rd_d;
        end
    end

    // Stop decisions; an output mapped to no request ignores requests
    always_comb begin
        mapped = '0;
        wanted = '0;
        for (int k = 0; k < N_REQ; k++) begin
            mapped = mapped | req_map_q[k];
            wanted = wanted | (req_map_q[k] & {N_SRC{req_low[k]}});
        end
        by_bus = src_bus_stop_q & {N_SRC{bus_halt}};
        stop_src = (mapped & ~wanted) | by_bus;
        stop_cpu = cpu_cfg_q[CPU_STOP_LSB +: N_CPU] & {N_CPU{cpu_halt}};
        stop_free = ~misc_q[MISC_FREE_LSB +: N_FREE] & {N_FREE{bus_halt}};
    end

    // Phase generators stand still while the oscillators are off
    assign ph_d = osc_en ? ~ph_q : ph_q;
    assign bcnt_d = osc_en ? bcnt_q + 2'h1 : bcnt_q;
    assign diff_rise = osc_en && !ph_q;
    assign diff_fall = osc_en && ph_q;
    assign bus_rise = osc_en && (bcnt_q == 2'h1);
    assign bus_fall = osc_en && (bcnt_q == 2'h3);

    // Gating moves only on phase edges, which keeps every pulse whole
    always_comb begin
        park_diff_d = park_diff_q;
        if (park && (!osc_en || diff_rise)) begin
            park_diff_d = 1'b1;
        end else if (!park && diff_rise) begin
            park_diff_d = 1'b0;
        end
        park_bus_d = park_bus_q;
        if (park && (!osc_en || bus_fall)) begin
            park_bus_d = 1'b1;
        end else if (!park && bus_rise) begin
            park_bus_d = 1'b0;
        end
        for (int i = 0; i < N_SRC; i++) begin
            run_src_d[i] = run_src_q[i];
            if (diff_fall && stop_src[i]) begin
                run_src_d[i] = 1'b0;
            end else if (diff_rise && !stop_src[i]) begin
                run_src_d[i] = 1'b1;
            end
        end
        for (int i = 0; i < N_CPU; i++) begin
            run_cpu_d[i] = run_cpu_q[i];
            if (diff_fall && stop_cpu[i]) begin
                run_cpu_d[i] = 1'b0;
            end else if (diff_rise && !stop_cpu[i]) begin
                run_cpu_d[i] = 1'b1;
            end
        end
        run_bus_d = run_bus_q;
        if (bus_fall && bus_halt) begin
            run_bus_d = 1'b0;
        end else if (bus_rise && !bus_halt) begin
            run_bus_d = 1'b1;
        end
        for (int j = 0; j < N_FREE; j++) begin
            run_free_d[j] = run_free_q[j];
            if (bus_fall && stop_free[j]) begin
                run_free_d[j] = 1'b0;
            end else if (bus_rise && !stop_free[j]) begin
                run_free_d[j] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ph_q <= 1'b0;
            bcnt_q <= 2'h0;
            park_diff_q <= 1'b1;
            park_bus_q <= 1'b1;
            run_src_q <= '1;
            run_cpu_q <= '1;
            run_bus_q <= 1'b1;
            run_free_q <= '1;
        end else begin
            ph_q <= ph_d;
            bcnt_q <= bcnt_d;
            park_diff_q <= park_diff_d;
            park_bus_q <= park_bus_d;
            run_src_q <= run_src_d;
            run_cpu_q <= run_cpu_d;
            run_bus_q <= run_bus_d;
            run_free_q <= run_free_d;
        end
    end

    // Differential pin drive, registered straight onto the pins
    always_ff @(posedge CLK or posedge RST) begin
        logic wake;
        logic disp_run;
        logic [3:0] v;
        if (RST) begin
            SRC_T <= '0;
            SRC_C <= '0;
            SRC_T_OE <= '0;
            SRC_C_OE <= '0;
            CPU_T <= '0;
            CPU_C <= '0;
            CPU_T_OE <= '0;
            CPU_C_OE <= '0;
            {DOT_T, DOT_C, DOT_T_OE, DOT_C_OE} <= 4'h0;
            {DISP_T, DISP_C, DISP_T_OE, DISP_C_OE} <= 4'h0;
        end else begin
            for (int i = 0; i < N_SRC; i++) begin
                // Pending restart pulls the pair high before its first edge
                wake = !run_src_d[i] && !stop_src[i];
                v = cos_pair(ph_d, run_src_d[i], park_diff_d, src_mode_q[i], release_hi,
                             wake || by_bus[i], src_mode_q[i] && !wake);
                {SRC_T[i], SRC_C[i], SRC_T_OE[i], SRC_C_OE[i]} <= v;
            end
            for (int i = 0; i < N_CPU; i++) begin
                v = cos_pair(ph_d, run_cpu_d[i], park_diff_d, cpu_cfg_q[CPU_MODE_LSB + i],
                             release_hi, 1'b1, cpu_cfg_q[CPU_MODE_LSB + i]);
                {CPU_T[i], CPU_C[i], CPU_T_OE[i], CPU_C_OE[i]} <= v;
            end
            {DOT_T, DOT_C, DOT_T_OE, DOT_C_OE} <= cos_pair(ph_d, 1'b1, park_diff_d,
                misc_q[MISC_DOT_MODE_BIT], release_hi, 1'b1, 1'b0);
            // Display clock takes the gating of whichever family it mimics
            disp_run = misc_q[MISC_DISP100_BIT] ? run_src_d[0] : 1'b1;
            {DISP_T, DISP_C, DISP_T_OE, DISP_C_OE} <= cos_pair(ph_d, disp_run, park_diff_d,
                misc_q[MISC_DISP_MODE_BIT], release_hi, 1'b0, src_mode_q[0]);
        end
    end

    // Single-ended clocks end low when stopped or parked
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BUS_CLK <= '0;
            FREE_BUS_CLK <= '0;
        end else begin
            BUS_CLK <= {N_BUS{run_bus_d && !park_bus_d && bcnt_d[1]}};
            for (int j = 0; j < N_FREE; j++) begin
                FREE_BUS_CLK[j] <= run_free_d[j] && !park_bus_d && bcnt_d[1];
            end
        end
    end

    // Oscillators only stop after the parking window has elapsed
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            OSC_ENABLE <= 1'b0;
            PLL_ENABLE <= 1'b0;
        end else begin
            OSC_ENABLE <= osc_en;
            PLL_ENABLE <= osc_en;
        end
    end
endmodule : cos_top

// file: cos_chk.sv
`timescale 1ns/1ns
module cos_chk
    import cos_pkg::*;
#(
    parameter int LOCK_CYC = 20
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic TERMINATION_POWER_GOOD_N,
    input wire logic [cos_pkg::N_SRC-1:0] SRC_T,
    input wire logic [cos_pkg::N_SRC-1:0] SRC_T_OE,
    input wire logic [cos_pkg::N_SRC-1:0] SRC_C_OE,
    input wire logic [cos_pkg::N_CPU-1:0] CPU_T,
    input wire logic [cos_pkg::N_CPU-1:0] CPU_C,
    input wire logic [cos_pkg::N_CPU-1:0] CPU_T_OE,
    input wire logic [cos_pkg::N_CPU-1:0] CPU_C_OE,
    input wire logic [cos_pkg::N_BUS-1:0] BUS_CLK,
    input wire logic [cos_pkg::N_FREE-1:0] FREE_BUS_CLK,
    input wire logic OSC_ENABLE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Shutdown is the last step of the park walk
    sequence s_go_off;
        $fell(OSC_ENABLE);
    endsequence
    a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing");
    a_off_needs_pd: assert property (s_go_off |-> $past(TERMINATION_POWER_GOOD_N, 3))
        else $error("shutdown without power-down");
    a_park_then_off: assert property (s_go_off |-> $past(BUS_CLK, 2) == '0)
        else $error("oscillator off before park");
    a_off_bus_low: assert property (!OSC_ENABLE |-> BUS_CLK == '0 && FREE_BUS_CLK == '0)
        else $error("bus clock not low");
    a_true_only_high: assert property ((SRC_T_OE & ~SRC_C_OE & ~SRC_T) == '0)
        else $error("lone true line not high");
    a_comp_needs_true: assert property ((SRC_C_OE & ~SRC_T_OE) == '0)
        else $error("complement driven alone");
    a_cpu_pair_diff: assert property ((CPU_T_OE & CPU_C_OE & ~(CPU_T ^ CPU_C)) == '0)
        else $error("driven cpu pair equal");
    a_bus_no_runt: assert property ($rose(BUS_CLK[0]) |=> BUS_CLK[0])
        else $error("bus clock runt");
endmodule : cos_chk

bind cos_top cos_chk #(.LOCK_CYC(LOCK_CYC)) u_chk (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .TERMINATION_POWER_GOOD_N(TERMINATION_POWER_GOOD_N),
    .SRC_T(SRC_T), .SRC_T_OE(SRC_T_OE), .SRC_C_OE(SRC_C_OE), .CPU_T(CPU_T), .CPU_C(CPU_C),
    .CPU_T_OE(CPU_T_OE), .CPU_C_OE(CPU_C_OE), .BUS_CLK(BUS_CLK), .FREE_BUS_CLK(FREE_BUS_CLK),
    .OSC_ENABLE(OSC_ENABLE));

// file: cos_pmc.sv
`timescale 1ns/1ns
module cos_pmc
    import cos_pkg::*;
(
    input wire logic clk,
    output logic [cos_pkg::N_REQ-1:0] req_n,
    output logic pg_n,
    output logic cpu_n,
    output logic bus_n
);
    // Shared pin starts not good, so the device must wait
    initial begin
        req_n = '0;
        pg_n = 1'b1;
        cpu_n = 1'b1;
        bus_n = 1'b1;
    end
    task put(input logic [N_REQ-1:0] r, input logic p, input logic c, input logic b);
        @(posedge clk);
        req_n <= r;
        pg_n <= p;
        cpu_n <= c;
        bus_n <= b;
    endtask : put
    task boot(input logic pd);
        put(req_n, 1'b0, cpu_n, bus_n);
        repeat (4) @(posedge clk);
        if (pd) begin
            put(req_n, 1'b1, cpu_n, bus_n);
        end
    endtask : boot
endmodule : cos_pmc

// file: tb_clock_output_stop_powerdown.sv
`timescale 1ns/1ns
module tb_clock_output_stop_powerdown;
    import cos_pkg::*;
    localparam int LK = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] dat_o, q;
    logic ack, osc, pll, pg_n, cpu_n, bus_n;
    logic [N_REQ-1:0] req_n;
    logic [N_SRC-1:0] s_t, s_c, s_to, s_co;
    logic [N_CPU-1:0] c_t, c_c, c_to, c_co;
    logic [N_BUS-1:0] bclk;
    logic [N_FREE-1:0] fclk;
    int mismatches = 0;
    int n_compared = 0;
    int n, k;
    // Address, reset value, write value, readback
    logic [31:0] rows [7] = '{32'h00000101, 32'h04005A5A, 32'h08000202, 32'h0C000000,
        32'h10033131, 32'h14011111, 32'h1C00FF00};
    always #5 clk = ~clk;
    cos_top #(.LOCK_CYC(LK)) uut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .SERIAL_REF_REQUEST_N(req_n), .TERMINATION_POWER_GOOD_N(pg_n),
        .PROCESSOR_CLOCK_HALT_N(cpu_n), .BUS_CLOCK_HALT_N(bus_n), .SRC_T(s_t), .SRC_C(s_c),
        .SRC_T_OE(s_to), .SRC_C_OE(s_co), .CPU_T(c_t), .CPU_C(c_c), .CPU_T_OE(c_to),
        .CPU_C_OE(c_co), .DOT_T(), .DOT_C(), .DOT_T_OE(), .DOT_C_OE(), .DISP_T(), .DISP_C(),
        .DISP_T_OE(), .DISP_C_OE(), .BUS_CLK(bclk), .FREE_BUS_CLK(fclk), .OSC_ENABLE(osc),
        .PLL_ENABLE(pll));
    cos_pmc pmc (.clk(clk), .req_n(req_n), .pg_n(pg_n), .cpu_n(cpu_n), .bus_n(bus_n));
    task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task conclude;
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    // Entered just after a rising edge; the bench timeout ends a hung wait
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic ticks(input int c);
        repeat (c) @(posedge clk);
    endtask : ticks
    initial begin
        ticks(12);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            wb(0, rows[i][31:24], 8'h00);
            chk(q, {24'h0, rows[i][23:16]}, "reset");
            wb(1, rows[i][31:24], rows[i][15:8]);
            wb(0, rows[i][31:24], 8'h00);
            chk(q, {24'h0, rows[i][7:0]}, "readback");
        end
        pmc.boot(1'b0);
        ticks(LK + 40);
        wb(0, REG_STATUS, 8'h00);
        chk(q[1], 1, "locked");
        pmc.put(2'b01, 0, 1, 1);
        ticks(12);
        chk({s_t[0], s_c[0], s_to[0], s_co[0]}, 4'h3, "req stop");
        pmc.put(2'b00, 0, 1, 1);
        n = 0;
        while (s_c[0] !== 1'b1 && n < 30) begin
            @(posedge clk);
            n++;
        end
        chk(n >= 2 && n <= 16, 1, "restart");
        // A one-cycle pulse must not stop the pair
        pmc.put(2'b01, 0, 1, 1);
        pmc.put(2'b00, 0, 1, 1);
        n = 0;
        repeat (10) begin
            @(posedge clk);
            n += s_c[0];
        end
        chk(n, 5, "glitch");
        pmc.put(2'b00, 0, 0, 1);
        ticks(12);
        chk({c_t[0], c_c[0], c_to[0], c_co[0]}, 0, "cpu tri stop");
        wb(1, REG_CPU_CFG, 8'h03);
        ticks(12);
        chk({c_t, c_c, c_to, c_co}, 8'hCF, "cpu driven stop");
        pmc.put(2'b00, 0, 1, 0);
        ticks(16);
        n = 0;
        k = 0;
        repeat (4) begin
            @(posedge clk);
            n += (bclk != 0);
            k += fclk[0] + 2 * fclk[1];
        end
        chk(n, 0, "bus stop");
        chk(k, 2, "free bus");
        chk({s_t[1], s_c[1], s_to[1], s_co[1]}, 4'hB, "src bus stop");
        pmc.put(2'b00, 0, 1, 1);
        n = 0;
        while (bclk !== 4'hF && n < 30) begin
            @(posedge clk);
            n++;
        end
        chk(n <= 12, 1, "bus restart");
        wb(1, REG_SRC_MODE, 8'h01);
        pmc.put(2'b00, 1, 1, 1);
        ticks(30);
        chk({osc, pll}, 2'b00, "osc off");
        chk({s_t[0], s_c[0], s_to[0], s_co[0]}, 0, "tri park");
        chk({s_t[2], s_c[2], s_to[2], s_co[2]}, 4'hA, "drive park");
        chk(bclk, 0, "bus park");
        pmc.put(2'b00, 0, 1, 1);
        ticks(8);
        chk({s_t[0], s_c[0], s_to[0], s_co[0]}, 4'hB, "release high");
        ticks(LK + 12);
        chk({s_to, pll}, 9'h1FF, "all on");
        chk(s_t, {8{s_t[0]}}, "together");
        pmc.put(2'b00, 1, 1, 1);
        rst <= 1'b1;
        ticks(2);
        chk({ack, osc, s_to}, 0, "in reset");
        rst <= 1'b0;
        @(posedge clk);
        wb(0, REG_CPU_CFG, 8'h00);
        chk(q, 32'h3, "cpu cfg");
        pmc.boot(1'b1);
        ticks(LK + 40);
        chk({osc, pll}, 2'b00, "initial pd");
        conclude();
    end
    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        conclude();
    end
endmodule : tb_clock_output_stop_powerdown
